// [async_serial_map.vh]
// register indices, field positions, encodings and timing counts of the serial adapter
// assumes inclusion by the adapter design file alone; definitions only
`ifndef ASYNC_SERIAL_MAP_VH
`define ASYNC_SERIAL_MAP_VH
// ==========================================================
// register select codes
`define REG_DATA 2'h0
`define REG_STATUS 2'h1
`define REG_COMMAND 2'h2
`define REG_CONTROL 2'h3
// ==========================================================
// line_status bits
`define ST_PE 0
`define ST_FE 1
`define ST_OVR 2
`define ST_RXF 3
`define ST_TXE 4
`define ST_DCD 5
`define ST_DSR 6
`define ST_IRQ 7
// ==========================================================
// frame_format_control fields
`define CT_RATE 3:0
`define CT_RXSRC 4
`define CT_WLEN 6:5
`define CT_STOP 7
// ==========================================================
// modem_command fields and encodings
`define CM_DTR 0
`define CM_RXOFF 1
`define CM_TXC 3:2
`define CM_ECHO 4
`define CM_PEN 5
`define CM_PTYPE 7:6
`define TXC_RTS_HI 2'h0
`define TXC_IRQ 2'h1
`define TXC_BREAK 2'h3
`define PAR_ODD 2'h0
`define PAR_EVEN 2'h1
`define PAR_MARK 2'h2
`define WLEN_5 2'h3
`define WLEN_8 2'h0
// ==========================================================
// reset values
`define CONTROL_RST 8'h00
`define COMMAND_RST 8'h00
// ==========================================================
// rate generator divisors of the crystal input
`define DIV_EXT 16'h0010
`define DIV_1 16'h9000
`define DIV_2 16'h6000
`define DIV_3 16'h4180
`define DIV_4 16'h3580
`define DIV_5 16'h3000
`define DIV_6 16'h1800
`define DIV_7 16'h0c00
`define DIV_8 16'h0600
`define DIV_9 16'h0400
`define DIV_10 16'h0300
`define DIV_11 16'h0200
`define DIV_12 16'h0180
`define DIV_13 16'h0100
`define DIV_14 16'h00c0
`define DIV_15 16'h0060
// ==========================================================
// oversample tick counts (16 ticks per bit)
`define T_BIT_END 6'h0f
`define T_START_MID 6'h07
`define T_HALF 8'h01
`define TX_STOP_1 6'h10
`define TX_STOP_15 6'h18
`define TX_STOP_2 6'h20
`define RX_STOP_SAMPLE 6'h10
`define RX_END_15 6'h1c
`define RX_END_2 6'h20
`endif

// [pin_sync.v]
// two-stage synchroniser with rising and any-change pulses
// assumes an asynchronous pin input and one system clock
`timescale 1ns/1ps
module pin_sync #(
   parameter INIT = 1'b1
) (
   input wire mclk,
   input wire rst,
   input wire pin,
   output reg level,
   output wire rise,
   output wire change
);
   reg meta;
   reg last;

   // only the second stage looks at meta
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         meta <= INIT;
         level <= INIT;
         last <= INIT;
      end else begin
         meta <= pin;
         level <= meta;
         last <= level;
      end
   end

   assign rise = level & ~last;
   assign change = level ^ last;
endmodule

// [async_serial_adapter.v]
// serial adapter: rate generator, transmitter, receiver, echo, modem lines, registers
// assumes a register port on mclk and asynchronous serial and modem pins
`timescale 1ns/1ps
`include "async_serial_map.vh"
module async_serial_adapter (
   input wire mclk,
   input wire rst,
   input wire [1:0] reg_addr,
   input wire reg_wr,
   input wire reg_rd,
   input wire [7:0] reg_wdata,
   output reg [7:0] reg_rdata,
   output reg irq_n,
   input wire crystal_input,
   input wire receive_clock_pin,
   output reg rx_clk_out,
   output reg rx_clk_oe,
   input wire rxd,
   output reg txd,
   output reg rts_n,
   input wire cts_n,
   output reg dtr_n,
   input wire dcd_n,
   input wire dsr_n
);
   localparam TX_IDLE = 3'h0, TX_START = 3'h1, TX_DATA = 3'h2, TX_PAR = 3'h3, TX_STOP = 3'h4, TX_BRK = 3'h5;
   localparam RX_IDLE = 3'h0, RX_START = 3'h1, RX_DATA = 3'h2, RX_PAR = 3'h3, RX_STOP = 3'h4, RX_BRK = 3'h5;

   reg [7:0] control;
   reg [7:0] command;
   wire xtal_rise, rxc_rise, rxd_s, cts_s, dcd_s, dsr_s;

   // ==========================================================
   // pin synchronisers
   pin_sync #(.INIT(1'b0)) u_xtal (.mclk(mclk), .rst(rst), .pin(crystal_input), .level(), .rise(xtal_rise),
      .change());
   pin_sync #(.INIT(1'b0)) u_rxc (.mclk(mclk), .rst(rst), .pin(receive_clock_pin), .level(), .rise(rxc_rise),
      .change());
   // idle-high pins keep the default reset level
   pin_sync u_rxd (.mclk(mclk), .rst(rst), .pin(rxd), .level(rxd_s), .rise(), .change());
   pin_sync u_cts (.mclk(mclk), .rst(rst), .pin(cts_n), .level(cts_s), .rise(), .change());
   pin_sync u_dcd (.mclk(mclk), .rst(rst), .pin(dcd_n), .level(dcd_s), .rise(), .change());
   pin_sync u_dsr (.mclk(mclk), .rst(rst), .pin(dsr_n), .level(dsr_s), .rise(), .change());

   // ==========================================================
   // decoded configuration
   wire enabled = command[`CM_DTR];
   wire [1:0] txc = command[`CM_TXC];
   wire echo = command[`CM_ECHO];
   wire par_en = command[`CM_PEN];
   wire [1:0] ptype = command[`CM_PTYPE];
   wire [1:0] wlen = control[`CT_WLEN];
   wire [2:0] last_bit = 3'h7 - {1'b0, wlen};
   wire [7:0] data_mask = 8'hff >> wlen;
   wire half_stop = control[`CT_STOP] && wlen == `WLEN_5 && !par_en;
   wire one_stop = !control[`CT_STOP] || (wlen == `WLEN_8 && par_en);
   wire [5:0] tx_stop_len = one_stop ? `TX_STOP_1 : (half_stop ? `TX_STOP_15 : `TX_STOP_2);
   wire [5:0] rx_end = one_stop ? `RX_STOP_SAMPLE : (half_stop ? `RX_END_15 : `RX_END_2);
   wire break_sel = txc == `TXC_BREAK;
   wire rd_data = reg_rd && reg_addr == `REG_DATA;
   wire rd_status = reg_rd && reg_addr == `REG_STATUS;
   wire wr_data = reg_wr && reg_addr == `REG_DATA;

   // ==========================================================
   // rate generator, 16x ticks
   reg [15:0] divisor;
   reg [11:0] brg_cnt;
   reg tx_tick;
   always @* begin
      case (control[`CT_RATE])
         4'h1: divisor = `DIV_1;
         4'h2: divisor = `DIV_2;
         4'h3: divisor = `DIV_3;
         4'h4: divisor = `DIV_4;
         4'h5: divisor = `DIV_5;
         4'h6: divisor = `DIV_6;
         4'h7: divisor = `DIV_7;
         4'h8: divisor = `DIV_8;
         4'h9: divisor = `DIV_9;
         4'ha: divisor = `DIV_10;
         4'hb: divisor = `DIV_11;
         4'hc: divisor = `DIV_12;
         4'hd: divisor = `DIV_13;
         4'he: divisor = `DIV_14;
         4'hf: divisor = `DIV_15;
         default: divisor = `DIV_EXT;
      endcase
   end
   wire [11:0] brg_reload = divisor[15:4] - 12'h001;

   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         brg_cnt <= 12'h000;
         tx_tick <= 1'b0;
      end else begin
         tx_tick <= 1'b0;
         if (xtal_rise) begin
            if (brg_cnt == 12'h000) begin
               brg_cnt <= brg_reload;
               tx_tick <= 1'b1;
            end else begin
               brg_cnt <= brg_cnt - 12'h001;
            end
         end
      end
   end
   // receive clock pin carries one mclk pulse per 16x tick when driven
   wire rx_tick = control[`CT_RXSRC] ? tx_tick : rxc_rise;

   // ==========================================================
   // transmitter
   reg [2:0] tx_state;
   reg [5:0] tx_cnt;
   reg [2:0] tx_bit;
   reg [7:0] tx_hold;
   reg [7:0] tx_shift;
   reg tx_par;
   reg tx_empty;
   reg tx_blank;
   reg tx_event;
   wire [7:0] hold_masked = tx_hold & data_mask;
   wire hold_ready = enabled && !tx_empty && !wr_data && !break_sel;
   reg next_par;
   always @* begin
      case (ptype)
         `PAR_ODD: next_par = ~^hold_masked;
         `PAR_EVEN: next_par = ^hold_masked;
         `PAR_MARK: next_par = 1'b1;
         default: next_par = 1'b0;
      endcase
   end

   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         tx_state <= TX_IDLE;
         tx_cnt <= 6'h00;
         tx_bit <= 3'h0;
         tx_hold <= 8'h00;
         tx_shift <= 8'hff;
         tx_par <= 1'b1;
         tx_empty <= 1'b1;
         tx_blank <= 1'b1;
         tx_event <= 1'b0;
      end else begin
         tx_event <= 1'b0;
         if (wr_data) begin
            tx_hold <= reg_wdata;
            tx_empty <= 1'b0;
         end
         if (tx_tick) begin
            tx_cnt <= tx_cnt + 6'h01;
            case (tx_state)
               TX_IDLE: begin
                  tx_cnt <= 6'h00;
                  if (hold_ready) begin
                     tx_shift <= hold_masked;
                     tx_par <= next_par;
                     tx_empty <= 1'b1;
                     tx_blank <= 1'b0;
                     tx_event <= 1'b1;
                     tx_state <= TX_START;
                  end else if (break_sel && tx_empty) begin
                     tx_state <= TX_BRK;
                  end
               end
               TX_START: begin
                  if (tx_blank && hold_ready) begin
                     tx_shift <= hold_masked;
                     tx_par <= next_par;
                     tx_empty <= 1'b1;
                     tx_blank <= 1'b0;
                     tx_event <= 1'b1;
                     tx_cnt <= 6'h00;
                  end else if (tx_cnt == `T_BIT_END) begin
                     tx_cnt <= 6'h00;
                     tx_bit <= 3'h0;
                     tx_state <= TX_DATA;
                  end
               end
               TX_DATA: begin
                  if (tx_cnt == `T_BIT_END) begin
                     tx_cnt <= 6'h00;
                     tx_shift <= {1'b1, tx_shift[7:1]};
                     tx_bit <= tx_bit + 3'h1;
                     if (tx_bit == last_bit) begin
                        tx_state <= par_en ? TX_PAR : TX_STOP;
                     end
                  end
               end
               TX_PAR: begin
                  if (tx_cnt == `T_BIT_END) begin
                     tx_cnt <= 6'h00;
                     tx_state <= TX_STOP;
                  end
               end
               TX_STOP: begin
                  if (tx_cnt == tx_stop_len - 6'h01) begin
                     tx_cnt <= 6'h00;
                     if (hold_ready) begin
                        tx_shift <= hold_masked;
                        tx_par <= next_par;
                        tx_empty <= 1'b1;
                        tx_blank <= 1'b0;
                        tx_event <= 1'b1;
                        tx_state <= TX_START;
                     end else if (break_sel && tx_empty) begin
                        tx_state <= TX_BRK;
                     end else if (enabled) begin
                        // idle frame keeps the interrupt cadence with the line at mark
                        tx_blank <= 1'b1;
                        tx_event <= 1'b1;
                        tx_state <= TX_START;
                     end else begin
                        tx_state <= TX_IDLE;
                     end
                  end
               end
               TX_BRK: begin
                  tx_cnt <= 6'h00;
                  if (!break_sel) begin
                     tx_blank <= 1'b1;
                     tx_state <= TX_STOP;
                  end
               end
               default: tx_state <= TX_IDLE;
            endcase
         end
      end
   end

   // ==========================================================
   // receiver
   reg [2:0] rx_state;
   reg [5:0] rx_cnt;
   reg [2:0] rx_bit;
   reg [7:0] rx_shift;
   reg [7:0] rx_hold;
   reg rx_par;
   reg stop_ok;
   reg rx_full;
   reg overrun;
   reg frame_err;
   reg par_err;
   reg rx_event;
   reg echo_mute;
   reg [7:0] echo_line;
   wire [7:0] rx_word = rx_shift >> wlen;
   wire par_bad = par_en && !ptype[1] && ((^rx_word ^ rx_par) != (ptype == `PAR_ODD));
   wire rx_done = rx_tick && rx_state == RX_STOP && rx_cnt == rx_end - 6'h01;
   wire stop_good = stop_ok && rxd_s;

   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         rx_state <= RX_IDLE;
         rx_cnt <= 6'h00;
         rx_bit <= 3'h0;
         rx_shift <= 8'h00;
         rx_hold <= 8'h00;
         rx_par <= 1'b0;
         stop_ok <= 1'b1;
         rx_full <= 1'b0;
         overrun <= 1'b0;
         frame_err <= 1'b0;
         par_err <= 1'b0;
         rx_event <= 1'b0;
         echo_mute <= 1'b0;
         echo_line <= 8'hff;
      end else begin
         rx_event <= 1'b0;
         if (rd_data) begin
            rx_full <= 1'b0;
            overrun <= 1'b0;
         end
         if (rx_tick) begin
            echo_line <= {echo_line[6:0], rxd_s};
            rx_cnt <= rx_cnt + 6'h01;
            case (rx_state)
               RX_IDLE: begin
                  rx_cnt <= 6'h00;
                  if (!rxd_s && enabled) begin
                     rx_state <= RX_START;
                     if (!rx_full) begin
                        echo_mute <= 1'b0;
                     end
                  end
               end
               RX_START: begin
                  if (rx_cnt == `T_START_MID) begin
                     rx_cnt <= 6'h00;
                     rx_bit <= 3'h0;
                     rx_state <= rxd_s ? RX_IDLE : RX_DATA;
                  end
               end
               RX_DATA: begin
                  if (rx_cnt == `T_BIT_END) begin
                     rx_cnt <= 6'h00;
                     rx_shift <= {rxd_s, rx_shift[7:1]};
                     rx_bit <= rx_bit + 3'h1;
                     if (rx_bit == last_bit) begin
                        rx_state <= par_en ? RX_PAR : RX_STOP;
                     end
                  end
               end
               RX_PAR: begin
                  if (rx_cnt == `T_BIT_END) begin
                     rx_cnt <= 6'h00;
                     rx_par <= rxd_s;
                     stop_ok <= 1'b1;
                     rx_state <= RX_STOP;
                  end
               end
               RX_STOP: begin
                  if (rx_cnt == `RX_STOP_SAMPLE - 6'h01) begin
                     stop_ok <= rxd_s;
                  end
                  if (rx_done) begin
                     rx_event <= 1'b1;
                     if (rx_full && !rd_data) begin
                        overrun <= 1'b1;
                        echo_mute <= 1'b1;
                     end else begin
                        rx_hold <= rx_word;
                        rx_full <= 1'b1;
                        frame_err <= !stop_good;
                        par_err <= par_bad;
                     end
                     stop_ok <= 1'b1;
                     rx_state <= stop_good ? RX_IDLE : RX_BRK;
                  end
               end
               RX_BRK: begin
                  rx_cnt <= 6'h00;
                  if (rxd_s) begin
                     rx_state <= RX_IDLE;
                  end
               end
               default: rx_state <= RX_IDLE;
            endcase
         end
      end
   end

   // ==========================================================
   // modem lines, interrupt and registers
   reg dcd_stat;
   reg dsr_stat;
   reg modem_hold;
   reg irq;
   wire modem_diff = !modem_hold && (dcd_s != dcd_stat || dsr_s != dsr_stat);
   wire tx_irq_ev = tx_event && enabled && txc == `TXC_IRQ && !echo;
   wire rx_irq_ev = rx_event && enabled && !command[`CM_RXOFF];
   wire modem_ev = modem_diff && enabled;
   // set wins over the read clear; error flags feed no event
   wire next_irq = tx_irq_ev || rx_irq_ev || modem_ev || (irq && !rd_status);
   wire [7:0] status = {irq, dsr_stat, dcd_stat, tx_empty && !cts_s, rx_full, overrun, frame_err, par_err};
   reg next_txd;
   always @* begin
      next_txd = 1'b1;
      if (echo) begin
         next_txd = echo_mute ? 1'b1 : echo_line[7];
      end else begin
         case (tx_state)
            TX_START: next_txd = tx_blank;
            // blank frames leave stale shift and parity bits behind; keep mark
            TX_DATA: next_txd = tx_shift[0] | tx_blank;
            TX_PAR: next_txd = tx_par | tx_blank;
            TX_BRK: next_txd = 1'b0;
            default: next_txd = 1'b1;
         endcase
      end
      if (cts_s) begin
         next_txd = 1'b1;
      end
   end

   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         control <= `CONTROL_RST;
         command <= `COMMAND_RST;
         dcd_stat <= 1'b1;
         dsr_stat <= 1'b1;
         modem_hold <= 1'b0;
         irq <= 1'b0;
         irq_n <= 1'b1;
         reg_rdata <= 8'h00;
         txd <= 1'b1;
         rts_n <= 1'b1;
         dtr_n <= 1'b1;
         rx_clk_out <= 1'b0;
         rx_clk_oe <= 1'b0;
      end else begin
         if (reg_wr && reg_addr == `REG_CONTROL) begin
            control <= reg_wdata;
         end
         if (reg_wr && reg_addr == `REG_COMMAND) begin
            command <= reg_wdata;
         end
         // disabled: levels follow the pins with no lock and no interrupt
         if (modem_diff || !enabled) begin
            dcd_stat <= dcd_s;
            dsr_stat <= dsr_s;
         end
         // a change landing on the status read locks again: set wins
         if (modem_ev) begin
            modem_hold <= 1'b1;
         end else if (rd_status) begin
            modem_hold <= 1'b0;
         end
         irq <= next_irq;
         irq_n <= !next_irq;
         if (reg_rd) begin
            case (reg_addr)
               `REG_DATA: reg_rdata <= rx_hold;
               `REG_STATUS: reg_rdata <= status;
               `REG_COMMAND: reg_rdata <= command;
               default: reg_rdata <= control;
            endcase
         end
         txd <= next_txd;
         rts_n <= !echo && txc == `TXC_RTS_HI;
         dtr_n <= !enabled;
         rx_clk_out <= tx_tick && control[`CT_RXSRC];
         rx_clk_oe <= control[`CT_RXSRC];
      end
   end
endmodule

// [async_serial_adapter_checker.sv]
// checker: register writes against pin levels and interrupt behaviour of the serial adapter
// assumes binding to async_serial_adapter, one clock mclk, async high reset rst
`timescale 1ns/1ps
module async_serial_adapter_checker (
   input wire mclk,
   input wire rst,
   input wire [1:0] reg_addr,
   input wire reg_wr,
   input wire reg_rd,
   input wire [7:0] reg_wdata,
   input wire [7:0] reg_rdata,
   input wire irq_n,
   input wire rx_clk_out,
   input wire rx_clk_oe,
   input wire txd,
   input wire rts_n,
   input wire cts_n,
   input wire dtr_n
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   // ==========================================
   // bus steps
   sequence s_cmd_wr; reg_wr && reg_addr == 2'h2; endsequence
   sequence s_ctl_wr; reg_wr && reg_addr == 2'h3; endsequence
   sequence s_stat_rd; reg_rd && reg_addr == 2'h1; endsequence
   // register write lands on the edge, the pin register follows one edge later
   property p_dtr; s_cmd_wr |-> ##2 dtr_n == !$past(reg_wdata[0], 2); endproperty
   a_dtr: assert property (p_dtr) else $error("dtr level wrong after command write");
   property p_dtr_src; !$stable(dtr_n) |-> $past(reg_wr && reg_addr == 2'h2, 2); endproperty
   a_dtr_src: assert property (p_dtr_src) else $error("dtr moved without command write");
   property p_rts; s_cmd_wr |-> ##2 rts_n == ($past(reg_wdata[3:2], 2) == 2'h0 && !$past(reg_wdata[4], 2)); endproperty
   a_rts: assert property (p_rts) else $error("rts level wrong after command write");
   property p_oe; s_ctl_wr |-> ##2 rx_clk_oe == $past(reg_wdata[4], 2); endproperty
   a_oe: assert property (p_oe) else $error("receive clock direction wrong");
   property p_out; (!rx_clk_oe) [*2] |-> !rx_clk_out; endproperty
   a_out: assert property (p_out) else $error("receive clock driven while input");
   // sync plus output register gives three cycles of grace
   property p_cts; cts_n [*4] |-> txd; endproperty
   a_cts: assert property (p_cts) else $error("txd not at mark while cts high");
   property p_irq_bit; s_stat_rd |=> reg_rdata[7] == !$past(irq_n); endproperty
   a_irq_bit: assert property (p_irq_bit) else $error("status bit 7 differs from irq");
   property p_irq_clr; s_stat_rd ##0 dtr_n |=> irq_n; endproperty
   a_irq_clr: assert property (p_irq_clr) else $error("irq not cleared by status read");
   property p_quiet; dtr_n [*2] ##0 irq_n |=> irq_n; endproperty
   a_quiet: assert property (p_quiet) else $error("interrupt raised while disabled");
endmodule
bind async_serial_adapter async_serial_adapter_checker chk_i (.mclk, .rst, .reg_addr, .reg_wr, .reg_rd,
   .reg_wdata, .reg_rdata, .irq_n, .rx_clk_out, .rx_clk_oe, .txd, .rts_n, .cts_n, .dtr_n);

// [serial_modem_model.sv]
// modem model: drives the receive line and modem status pins, samples the transmit line
// assumes the bench sets bit_ns and calls the tasks; the line idles at mark
`timescale 1ns/1ps
module serial_modem_model (
   input wire txd,
   output reg rxd,
   output reg cts_n,
   output reg dcd_n,
   output reg dsr_n
);
   real bit_ns = 640.0;
   initial begin
      rxd = 1'b1;
      {cts_n, dcd_n, dsr_n} = 3'h0;
   end
   task lines(input [2:0] v);
      {cts_n, dcd_n, dsr_n} = v;
   endtask
   // ==========================================
   // frame out lsb first; par below 0 means none; stop low is held two bits (break)
   task send(input [7:0] d, input integer n, input integer par, input stop);
      integer i;
      rxd = 1'b0;
      #(bit_ns);
      for (i = 0; i < n; i = i + 1) begin
         rxd = d[i];
         #(bit_ns);
      end
      if (par >= 0) begin
         rxd = par[0];
         #(bit_ns);
      end
      rxd = stop;
      #(2.0 * bit_ns);
      rxd = 1'b1;
      #(bit_ns);
   endtask
   // bounded wait for a start bit, then n mid-bit samples; zero word on timeout
   task recv(input integer n, output [9:0] w);
      integer i;
      w = 10'h000;
      for (i = 0; i < 20000 && txd !== 1'b0; i = i + 1)
         #10;
      if (txd === 1'b0) begin
         #(1.5 * bit_ns);
         for (i = 0; i < n; i = i + 1) begin
            w[i] = txd;
            #(bit_ns);
         end
      end
   endtask
endmodule

// [test_async_serial_adapter.sv]
// bench: register accesses and modem-side frames against expected status and line values
// assumes serial_modem_model and the bound checker; crystal and receive clock at 25 MHz
`timescale 1ns/1ps
module test_async_serial_adapter;
   reg mclk, rst, reg_wr, reg_rd, crystal_input, receive_clock_pin;
   reg [1:0] reg_addr;
   reg [7:0] reg_wdata, d;
   wire [7:0] reg_rdata;
   wire irq_n, rx_clk_out, rx_clk_oe, rxd, txd, rts_n, cts_n, dtr_n, dcd_n, dsr_n;
   integer bad_count = 0;
   integer check_count = 0;
   integer i, n;
   reg [9:0] v, w;
   reg pb;
   async_serial_adapter dut (.mclk, .rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .irq_n,
      .crystal_input, .receive_clock_pin, .rx_clk_out, .rx_clk_oe, .rxd, .txd, .rts_n, .cts_n, .dtr_n,
      .dcd_n, .dsr_n);
   serial_modem_model modem (.txd, .rxd, .cts_n, .dcd_n, .dsr_n);
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   initial begin
      crystal_input = 1'b0;
      forever #20 crystal_input = ~crystal_input;
   end
   initial begin
      receive_clock_pin = 1'b0;
      #7;
      forever #20 receive_clock_pin = ~receive_clock_pin;
   end
   // ==========================================
   // bus and compare tasks
   task chk(input [9:0] got, input [9:0] exp);
      check_count = check_count + 1;
      if (got !== exp) begin
         bad_count = bad_count + 1;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task complete_run;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task wr(input [1:0] a, input [7:0] x);
      @(posedge mclk);
      #1;
      reg_addr = a;
      reg_wdata = x;
      reg_wr = 1'b1;
      @(posedge mclk);
      #1 reg_wr = 1'b0;
   endtask
   task rd(input [1:0] a, output [9:0] x);
      @(posedge mclk);
      #1;
      reg_addr = a;
      reg_rd = 1'b1;
      @(posedge mclk);
      #1 reg_rd = 1'b0;
      x = {2'h0, reg_rdata};
   endtask
   task wirq;
      integer k;
      for (k = 0; k < 5000 && irq_n !== 1'b0; k = k + 1)
         @(posedge mclk);
      if (irq_n !== 1'b0) begin
         bad_count = bad_count + 1;
         complete_run;
      end
   endtask
   function pbit(input [7:0] x, input [1:0] t);
      case (t)
         2'h0: pbit = ~^x;
         2'h1: pbit = ^x;
         2'h2: pbit = 1'b1;
         default: pbit = 1'b0;
      endcase
   endfunction
   // ==========================================
   // scenarios
   initial begin
      {rst, reg_wr, reg_rd, reg_addr, reg_wdata} = 13'h1000;
      repeat (5) @(posedge mclk);
      #1 rst = 1'b0;
      repeat (4) @(posedge mclk);
      rd(1, v);
      chk(v, 10'h010);
      rd(2, v);
      chk(v, 10'h000);
      chk({9'h0, dtr_n}, 10'h001);
      rd(3, v);
      chk(v, 10'h000);
      // every word length and parity type; odd loops take the receive clock from the transmitter
      for (i = 0; i < 4; i = i + 1) begin
         n = 8 - i;
         d = 8'h96 ^ i[7:0];
         wr(3, {1'b1, i[1:0], i[0], 4'h0});
         wr(2, {i[1:0], 6'h25});
         wr(0, d);
         modem.recv(n + 2, w);
         d = d & (8'hff >> i);
         pb = pbit(d, i[1:0]);
         chk(w, {2'h0, d} | ({9'h001, pb} << n));
         wirq;
         rd(1, v);
         chk({9'h0, v[7]}, 10'h001);
         wr(2, {i[1:0], 6'h29});
         rd(1, v);
         modem.send(d, n, 1 - pb, 1'b1);
         wirq;
         rd(1, v);
         chk(v, {9'h04c, i < 2});
         rd(0, v);
         chk(v, {2'h0, d});
      end
      wr(3, 8'h10);
      wr(2, 8'h09);
      modem.send(8'h00, 8, -1, 1'b0);
      rd(1, v);
      chk(v, 10'h09a);
      rd(0, v);
      modem.send(8'hc3, 8, -1, 1'b1);
      rd(1, v);
      chk(v, 10'h098);
      rd(0, v);
      modem.send(8'h11, 8, -1, 1'b1);
      modem.send(8'h22, 8, -1, 1'b1);
      rd(1, v);
      chk(v, 10'h09c);
      rd(0, v);
      chk(v, 10'h011);
      rd(1, v);
      chk(v, 10'h010);
      modem.lines(3'h4);
      wr(0, 8'h55);
      // long enough for the word to leave the holding register, so the empty flag is really hidden
      repeat (800) @(posedge mclk);
      rd(1, v);
      chk(v, 10'h000);
      modem.lines(3'h2);
      wirq;
      rd(1, v);
      chk(v, 10'h0b0);
      modem.lines(3'h1);
      wirq;
      rd(1, v);
      chk(v, 10'h0d0);
      modem.lines(3'h0);
      wirq;
      rd(1, v);
      chk(v, 10'h090);
      wr(2, 8'h00);
      modem.lines(3'h2);
      repeat (10) @(posedge mclk);
      chk({9'h0, irq_n}, 10'h001);
      modem.lines(3'h0);
      // echo at the fastest internal rate: divisor 96 gives a bit of 96 crystal periods
      wr(3, 8'h1f);
      wr(2, 8'h13);
      modem.bit_ns = 3840.0;
      fork
         modem.send(8'h5a, 8, -1, 1'b1);
         modem.recv(10, w);
      join
      chk(w, 10'h35a);
      chk({9'h0, rts_n}, 10'h000);
      complete_run;
   end
endmodule
